// ---- dv/rtcm_asserts.sv ----
// Port-level checker for the RTC mask, validity and divider block.
// Assumes it is bound to rtcm_top and sees only that module's ports.
`timescale 1ns/1ps
module rtcm_asserts
    import rtcm_pkg::*;
(
    input wire logic                          aclk,
    input wire logic                          aresetn,
    input wire logic                          s_axi_awvalid,
    input wire logic                          s_axi_awready,
    input wire logic                          s_axi_wvalid,
    input wire logic                          s_axi_wready,
    input wire logic [1:0]                    s_axi_bresp,
    input wire logic                          s_axi_bvalid,
    input wire logic                          s_axi_bready,
    input wire logic                          s_axi_arvalid,
    input wire logic                          s_axi_arready,
    input wire logic [rtcm_pkg::AXI_DW-1:0]   s_axi_rdata,
    input wire logic                          s_axi_rvalid,
    input wire logic                          s_axi_rready,
    input wire logic [rtcm_pkg::NUM_SRC-1:0]  source_event,
    input wire logic                          tick_100hz,
    input wire logic                          timekeeping_reset,
    input wire logic                          rtc_soft_reset,
    input wire logic                          rtc_irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Set once any write has completed
    logic wr_seen_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) wr_seen_reg <= 1'b0;
        else if (s_axi_bvalid) wr_seen_reg <= 1'b1;
    end

    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read data late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_irq_cause: assert property (
        $rose(rtc_irq) |-> |$past(source_event, 2))
        else $error("interrupt rose without an event");
    a_keep_pair: assert property (
        timekeeping_reset |-> rtc_soft_reset)
        else $error("timekeeping reset without soft reset");
    a_soft_no_tick: assert property (
        rtc_soft_reset [*3] |-> !tick_100hz)
        else $error("tick during soft reset");
    a_tick_needs_en: assert property (
        tick_100hz |-> wr_seen_reg)
        else $error("tick before divider enabled");
endmodule // rtcm_asserts

bind rtcm_top rtcm_asserts chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .source_event, .tick_100hz, .timekeeping_reset,
    .rtc_soft_reset, .rtc_irq
);

// ---- dv/test_rtc_irq_mask_status_divider.sv ----
// Self-checking bench for the RTC mask, validity and divider block.
// Assumes rtcm_top with its checker bound; drives all ports directly.
`timescale 1ns/1ps
module test_rtc_irq_mask_status_divider;
    import rtcm_pkg::*;
    logic        aclk, aresetn, tick_100hz, rtc_irq;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb, invalid_entry;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [6:0]  source_event;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, timekeeping_reset;
    logic        rtc_soft_reset;
    logic [31:0] rst_pair;
    int          num_errors = 0;
    int          checked = 0;
    int          cyc = 0;

    assign rst_pair = {30'h0, rtc_soft_reset, timekeeping_reset};

    rtcm_top dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .source_event, .invalid_entry, .tick_100hz, .timekeeping_reset,
        .rtc_soft_reset, .rtc_irq
    );

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, d,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rdc(input logic [31:0] a, exp,
                       input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        chk(s_axi_rdata, exp);
    endtask

    // One-cycle pulses from the time core, then two cycles to settle
    task automatic pulse(input logic [6:0] ev, input logic [3:0] inv);
        @(posedge aclk);
        source_event  <= ev;
        invalid_entry <= inv;
        @(posedge aclk);
        source_event  <= 7'h0;
        invalid_entry <= 4'h0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic t_reset_values();
        rdc(ADDR_MASK_STATE, 32'h7f);
        rdc(ADDR_VALIDITY, 32'hf);
        rdc(ADDR_RETAIN, 32'h1);
        rdc(ADDR_TICK_DIV, 32'h00051ea8);
        rdc(ADDR_IRQ_UNMASK, 32'h0);
        rdc(ADDR_IRQ_MASK_WR, 32'h0);
        rdc(32'h50004138, 32'h0, RESP_SLVERR);
        wr(32'h50004138, 32'hffffffff, RESP_SLVERR);
        wr(ADDR_MASK_STATE, 32'h0);
        rdc(ADDR_MASK_STATE, 32'h7f);
    endtask

    task automatic t_mask_sources();
        logic [6:0] m;
        m = 7'h7f;
        for (int i = 0; i < 7; i++) begin
            pulse(7'h1 << i, 4'h0);
            chk({31'h0, rtc_irq}, 32'h0);
            wr(ADDR_IRQ_UNMASK, 32'h1 << i);
            m[i] = 1'b0;
            rdc(ADDR_MASK_STATE, {25'h0, m});
            rdc(ADDR_EVENT_FLAGS, 32'h0);
            pulse(7'h1 << i, 4'h0);
            chk({31'h0, rtc_irq}, 32'h1);
            rdc(ADDR_EVENT_FLAGS, 32'h1 << i);
            wr(ADDR_EVENT_CLEAR, 32'h1 << i);
            repeat (2) @(posedge aclk);
            chk({31'h0, rtc_irq}, 32'h0);
        end
        for (int i = 6; i >= 0; i--) begin
            wr(ADDR_IRQ_MASK_WR, 32'h1 << i);
            m[i] = 1'b1;
            rdc(ADDR_MASK_STATE, {25'h0, m});
        end
        pulse(7'h7f, 4'h0);
        chk({31'h0, rtc_irq}, 32'h0);
    endtask

    task automatic t_validity();
        logic [3:0] v;
        v = 4'hf;
        for (int j = 0; j < 4; j++) begin
            pulse(7'h0, 4'h1 << j);
            v[j] = 1'b0;
            rdc(ADDR_VALIDITY, {28'h0, v});
        end
        rdc(ADDR_VALIDITY, 32'h0);
    endtask

    task automatic t_soft_reset();
        wr(ADDR_IRQ_UNMASK, 32'h7f);
        wr(ADDR_TICK_DIV, 32'h00251ea8);
        repeat (2) @(posedge aclk);
        chk(rst_pair, 32'h2);
        rdc(ADDR_MASK_STATE, 32'h7f);
        rdc(ADDR_VALIDITY, 32'h0);
        wr(ADDR_TICK_DIV, 32'h00051ea8);
        wr(ADDR_RETAIN, 32'h0);
        wr(ADDR_IRQ_UNMASK, 32'h1);
        pulse(7'h1, 4'h0);
        wr(ADDR_TICK_DIV, 32'h00251ea8);
        repeat (2) @(posedge aclk);
        chk(rst_pair, 32'h3);
        rdc(ADDR_VALIDITY, 32'hf);
        rdc(ADDR_EVENT_FLAGS, 32'h0);
        rdc(ADDR_MASK_STATE, 32'h7f);
        rdc(ADDR_RETAIN, 32'h0);
        rdc(ADDR_TICK_DIV, 32'h00251ea8);
        wr(ADDR_TICK_DIV, 32'h00051ea8);
        wr(ADDR_RETAIN, 32'h1);
        repeat (2) @(posedge aclk);
        chk(rst_pair, 32'h0);
    endtask

    // Divisor 3, fraction 2: one whole window holds 2 long periods
    task automatic t_tick(input logic sel);
        int          n;
        int          c;
        int          w;
        logic [31:0] d;
        w = sel ? 1024 : 1000;
        d = 32'h00100c02 | ({31'h0, sel} << 19);
        wr(ADDR_TICK_DIV, d);
        n = 0;
        while (!tick_100hz && n < 40) begin
            @(posedge aclk);
            n++;
        end
        c = 0;
        n = 0;
        while (n < w) begin
            @(posedge aclk);
            c++;
            if (tick_100hz) n++;
        end
        chk(c, 2 * 4 + (w - 2) * 3);
        rdc(ADDR_TICK_DIV, d);
        wr(ADDR_TICK_DIV, 32'h00000c02);
        repeat (2) @(posedge aclk);
        n = 0;
        repeat (30) begin
            @(posedge aclk);
            if (tick_100hz) n++;
        end
        chk(n, 0);
    endtask

    initial begin
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awprot, s_axi_arprot, source_event, invalid_entry} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_values();
        t_mask_sources();
        t_validity();
        t_soft_reset();
        t_tick(1'b0);
        t_tick(1'b1);
        complete_run();
    end
endmodule // test_rtc_irq_mask_status_divider

// ---- hw/rtcm_top.sv ----
// RTC interrupt mask, entry validity, retain control and 100 Hz divider.
// Assumes AXI4-Lite master on aclk; event and invalid-entry pulses come
// from the timekeeping core, one aclk cycle wide.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps

module rtcm_top
    import rtcm_pkg::*;
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite write address
    input  wire logic [rtcm_pkg::AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [rtcm_pkg::AXI_DW-1:0]   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [rtcm_pkg::AXI_AW-1:0]   s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    // AXI4-Lite read data
    output logic [rtcm_pkg::AXI_DW-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Timekeeping core
    input  wire logic [rtcm_pkg::NUM_SRC-1:0]  source_event,
    input  wire logic [rtcm_pkg::NUM_VALID-1:0] invalid_entry,
    output logic                               tick_100hz,
    output logic                               timekeeping_reset,
    output logic                               rtc_soft_reset,
    output logic                               rtc_irq
);
    import rtcm_pkg::*;

    // Write channel holding state
    logic                    aw_full_reg;
    logic [AXI_AW-1:0]       awaddr_reg;
    logic                    w_full_reg;
    logic [AXI_DW-1:0]       wdata_reg;
    logic [3:0]              wstrb_reg;
    logic                    awready_reg;
    logic                    wready_reg;
    logic                    bvalid_reg;
    logic [1:0]              bresp_reg;
    // Read channel state
    logic                    arready_reg;
    logic                    rvalid_reg;
    logic [AXI_DW-1:0]       rdata_reg;
    logic [1:0]              rresp_reg;
    // Block registers
    logic [NUM_SRC-1:0]      mask_reg;
    logic [NUM_SRC-1:0]      pending_reg;
    logic [NUM_VALID-1:0]    valid_reg;
    logic                    retain_reg;
    logic [DIV_WIDTH-1:0]    div_reg;
    // Divider state and output registers
    logic [9:0]              cycle_cnt_reg;
    logic [9:0]              window_idx_reg;
    logic                    tick_reg;
    logic                    irq_reg;
    logic                    tk_reset_reg;
    logic                    soft_reset_reg;

    // Decoded write strobes
    logic                    aw_hs;
    logic                    w_hs;
    logic                    wr_go;
    logic                    wr_hit;
    logic                    wr_lane0;
    logic [NUM_SRC-1:0]      unmask_wr;
    logic [NUM_SRC-1:0]      mask_wr;
    logic [NUM_SRC-1:0]      event_clr;
    logic                    soft_rst;
    logic                    wipe_linked;
    // Read decode
    logic [AXI_DW-1:0]       rd_data;
    logic                    rd_hit;
    // Divider arithmetic
    logic [9:0]              div_int;
    logic [9:0]              div_frac;
    logic [9:0]              period;
    logic [9:0]              period_last;
    logic [9:0]              window_last;
    logic                    period_end;

    assign s_axi_awready     = awready_reg;
    assign s_axi_wready      = wready_reg;
    assign s_axi_bvalid      = bvalid_reg;
    assign s_axi_bresp       = bresp_reg;
    assign s_axi_arready     = arready_reg;
    assign s_axi_rvalid      = rvalid_reg;
    assign s_axi_rdata       = rdata_reg;
    assign s_axi_rresp       = rresp_reg;
    assign tick_100hz        = tick_reg;
    assign rtc_irq           = irq_reg;
    assign timekeeping_reset = tk_reset_reg;
    assign rtc_soft_reset    = soft_reset_reg;

    assign aw_hs = s_axi_awvalid & awready_reg;
    assign w_hs  = s_axi_wvalid & wready_reg;
    assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;

    // Write address decode
    always_comb begin
        wr_hit   = 1'b0;
        wr_lane0 = wr_go & wstrb_reg[0];
        case (awaddr_reg)
            ADDR_IRQ_UNMASK,
            ADDR_IRQ_MASK_WR,
            ADDR_EVENT_CLEAR,
            ADDR_RETAIN,
            ADDR_TICK_DIV,
            ADDR_EVENT_FLAGS,
            ADDR_MASK_STATE,
            ADDR_VALIDITY: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // Write-only strobes act once and are not kept
    assign unmask_wr = (wr_lane0 && awaddr_reg == ADDR_IRQ_UNMASK)
                     ? wdata_reg[NUM_SRC-1:0] : '0;
    assign mask_wr   = (wr_lane0 && awaddr_reg == ADDR_IRQ_MASK_WR)
                     ? wdata_reg[NUM_SRC-1:0] : '0;
    assign event_clr = (wr_lane0 && awaddr_reg == ADDR_EVENT_CLEAR)
                     ? wdata_reg[NUM_SRC-1:0] : '0;

    // Soft reset while the request bit is held
    assign soft_rst    = div_reg[DIV_RESET_REQ];
    // Linked state wiped only when retain is off
    assign wipe_linked = soft_rst & ~retain_reg;

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awaddr_reg  <= '0;
            awready_reg <= 1'b1;
        end else if (aw_hs) begin
            aw_full_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
            awready_reg <= 1'b0;
        end else if (wr_go) begin
            aw_full_reg <= 1'b0;
            awready_reg <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
            wready_reg <= 1'b1;
        end else if (w_hs) begin
            w_full_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
            wready_reg <= 1'b0;
        end else if (wr_go) begin
            w_full_reg <= 1'b0;
            wready_reg <= 1'b1;
        end
    end

    // Write response channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read decode
    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            ADDR_EVENT_FLAGS: begin
                rd_data[NUM_SRC-1:0] = pending_reg;
            end
            ADDR_MASK_STATE: begin
                rd_data[NUM_SRC-1:0] = mask_reg;
            end
            ADDR_VALIDITY: begin
                rd_data[NUM_VALID-1:0] = valid_reg;
            end
            ADDR_RETAIN: begin
                rd_data[0] = retain_reg;
            end
            ADDR_TICK_DIV: begin
                rd_data[DIV_WIDTH-1:0] = div_reg;
            end
            ADDR_IRQ_UNMASK,
            ADDR_IRQ_MASK_WR,
            ADDR_EVENT_CLEAR: begin
                rd_data = '0;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_data;
            rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // Mask bits, one per source
    generate
        for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    mask_reg[i] <= MASK_RST[i];
                end else if (soft_rst) begin
                    mask_reg[i] <= MASK_RST[i];
                end else if (unmask_wr[i]) begin
                    mask_reg[i] <= 1'b0;
                end else if (mask_wr[i]) begin
                    mask_reg[i] <= 1'b1;
                end
            end

            // Sticky flag, set only while unmasked; set beats clear
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pending_reg[i] <= 1'b0;
                end else if (source_event[i] && !mask_reg[i]) begin
                    pending_reg[i] <= 1'b1;
                end else if (wipe_linked || event_clr[i]) begin
                    pending_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Validity flags; an invalid entry beats a soft reset
    generate
        for (genvar v = 0; v < NUM_VALID; v++) begin : g_val
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    valid_reg[v] <= VALID_RST[v];
                end else if (invalid_entry[v]) begin
                    valid_reg[v] <= 1'b0;
                end else if (wipe_linked) begin
                    valid_reg[v] <= VALID_RST[v];
                end
            end
        end
    endgenerate

    // Retain bit, spared by soft reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            retain_reg <= RETAIN_RST;
        end else if (wr_lane0 && awaddr_reg == ADDR_RETAIN) begin
            retain_reg <= wdata_reg[0];
        end
    end

    // Divider control register, byte lanes honoured, spared by soft reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= DIV_RST;
        end else if (wr_go && awaddr_reg == ADDR_TICK_DIV) begin
            for (int b = 0; b < 3; b++) begin
                if (wstrb_reg[b]) begin
                    for (int k = 0; k < 8; k++) begin
                        if (b * 8 + k < DIV_WIDTH) begin
                            div_reg[b * 8 + k] <= wdata_reg[b * 8 + k];
                        end
                    end
                end
            end
        end
    end

    // Period of the current tick; zero divisor treated as one
    assign div_int  = {1'b0, div_reg[DIV_INT_HI:DIV_INT_LO]};
    assign div_frac = div_reg[DIV_FRAC_HI:DIV_FRAC_LO];
    always_comb begin
        period = div_int;
        if (window_idx_reg < div_frac) begin
            period = div_int + 10'h001;
        end
        if (period == 10'h000) begin
            period = 10'h001;
        end
    end
    assign period_last = period - 10'h001;
    assign window_last = div_reg[DIV_WINDOW_SEL] ? WINDOW_1024_LAST
                                                 : WINDOW_1000_LAST;
    assign period_end  = (cycle_cnt_reg >= period_last);

    // Cycle counter within one tick period
    always_ff @(posedge aclk) begin
        if (!aresetn || !div_reg[DIV_ENABLE] || soft_rst) begin
            cycle_cnt_reg <= '0;
        end else if (period_end) begin
            cycle_cnt_reg <= '0;
        end else begin
            cycle_cnt_reg <= cycle_cnt_reg + 10'h001;
        end
    end

    // Period index within the fractional window
    always_ff @(posedge aclk) begin
        if (!aresetn || !div_reg[DIV_ENABLE] || soft_rst) begin
            window_idx_reg <= '0;
        end else if (period_end) begin
            if (window_idx_reg >= window_last) begin
                window_idx_reg <= '0;
            end else begin
                window_idx_reg <= window_idx_reg + 10'h001;
            end
        end
    end

    // Tick pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= div_reg[DIV_ENABLE] & ~soft_rst & period_end;
        end
    end

    // Interrupt level from unmasked pending events
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(pending_reg & ~mask_reg);
        end
    end

    // Reset outputs toward the timekeeping core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tk_reset_reg   <= 1'b0;
            soft_reset_reg <= 1'b0;
        end else begin
            tk_reset_reg   <= wipe_linked;
            soft_reset_reg <= soft_rst;
        end
    end

endmodule // rtcm_top

// ---- include/rtcm_pkg.sv ----
// Constants for the RTC mask, validity and tick divider block.
// Assumes a 32-bit AXI4-Lite register bus at byte addresses.
package rtcm_pkg;

    localparam int          AXI_AW           = 32;
    localparam int          AXI_DW           = 32;
    localparam int          NUM_SRC          = 7;
    localparam int          NUM_VALID        = 4;

    // Register byte addresses
    localparam logic [31:0] ADDR_EVENT_FLAGS = 32'h5000411c;
    localparam logic [31:0] ADDR_IRQ_UNMASK  = 32'h50004120;
    localparam logic [31:0] ADDR_IRQ_MASK_WR = 32'h50004124;
    localparam logic [31:0] ADDR_MASK_STATE  = 32'h50004128;
    localparam logic [31:0] ADDR_VALIDITY    = 32'h5000412c;
    localparam logic [31:0] ADDR_RETAIN      = 32'h50004130;
    localparam logic [31:0] ADDR_EVENT_CLEAR = 32'h50004134;
    localparam logic [31:0] ADDR_TICK_DIV    = 32'h5000424c;

    // Source bit positions in mask, enable, disable and event layouts
    localparam int          SRC_CENTISECOND  = 0;
    localparam int          SRC_SECOND       = 1;
    localparam int          SRC_MINUTE       = 2;
    localparam int          SRC_HOUR         = 3;
    localparam int          SRC_DAY          = 4;
    localparam int          SRC_MONTH        = 5;
    localparam int          SRC_ALARM        = 6;

    // Validity bit positions
    localparam int          VAL_TIME         = 0;
    localparam int          VAL_CALENDAR     = 1;
    localparam int          VAL_TIME_ALARM   = 2;
    localparam int          VAL_CAL_ALARM    = 3;

    // Divider register fields
    localparam int          DIV_RESET_REQ    = 21;
    localparam int          DIV_ENABLE       = 20;
    localparam int          DIV_WINDOW_SEL   = 19;
    localparam int          DIV_INT_HI       = 18;
    localparam int          DIV_INT_LO       = 10;
    localparam int          DIV_FRAC_HI      = 9;
    localparam int          DIV_FRAC_LO      = 0;
    localparam int          DIV_WIDTH        = 22;

    // Reset values
    localparam logic [6:0]  MASK_RST         = 7'h7f;
    localparam logic [3:0]  VALID_RST        = 4'hf;
    localparam logic        RETAIN_RST       = 1'h1;
    localparam logic [8:0]  DIV_INT_RST      = 9'h147;
    localparam logic [9:0]  DIV_FRAC_RST     = 10'h2a8;
    localparam logic [21:0] DIV_RST          = {1'h0, 1'h0, 1'h0,
                                                DIV_INT_RST,
                                                DIV_FRAC_RST};

    // Fractional window lengths, minus one
    localparam logic [9:0]  WINDOW_1000_LAST = 10'h3e7;
    localparam logic [9:0]  WINDOW_1024_LAST = 10'h3ff;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage : rtcm_pkg
